// ==== hdl/ciw_pkg.sv ====
package ciw_pkg;
	// Register word addresses (byte address = 4 * index on Avalon)
	localparam logic [5:0] CIW_IDX_CTRL0 = 6'h00; // Wake enable, sleep request
	localparam logic [5:0] CIW_IDX_CTRL1 = 6'h01; // Module enable, wake filter select
	localparam logic [5:0] CIW_IDX_RFLG = 6'h02; // Receive-side sticky flags
	localparam logic [5:0] CIW_IDX_RIER = 6'h03; // Receive-side irq enables
	localparam logic [5:0] CIW_IDX_TFLG = 6'h04; // Transmit-empty flags
	localparam logic [5:0] CIW_IDX_TIER = 6'h05; // Transmit-empty irq enables
	localparam logic [5:0] CIW_IDX_TSCHED = 6'h06; // Write 1 schedules a buffer
	localparam logic [5:0] CIW_IDX_IDBASE = 6'h10; // Identifier bytes: base + 4*buf + byte
	localparam logic [5:0] CIW_IDX_PRIO = 6'h07; // Highest-priority scheduled buffer
	// Field positions
	localparam int CIW_CTRL0_WAKE_EN = 2; // wake_enable
	localparam int CIW_CTRL0_SLEEP = 0; // Sleep request
	localparam int CIW_CTRL1_MOD_EN = 7; // module_enable_bit
	localparam int CIW_CTRL1_WFILT = 2; // wake_filter_select
	localparam int CIW_RF_WAKE = 7; // wake_flag
	localparam int CIW_RF_CSC = 6; // status_change_flag
	localparam int CIW_RF_OVR = 1; // overrun_flag
	localparam int CIW_RF_RXF = 0; // receive_full_flag
	// Reset values
	localparam logic [7:0] CIW_CTRL0_RST = 8'h00;
	localparam logic [7:0] CIW_CTRL1_RST = 8'h00; // Module enable low: disabled
	localparam logic [2:0] CIW_TXE_RST = 3'h7; // All transmit buffers empty
	// Counts
	localparam int CIW_NUM_TX = 3; // Transmit buffers
	localparam int CIW_NUM_BUF = 4; // Three transmit plus one receive
	localparam int CIW_ID_W = 29; // Extended identifier width
	localparam int CIW_FILT_NS = 2000; // Least wake pulse length when filtered
	localparam int CIW_CLK_MHZ = 40;
	localparam int CIW_FILT_CYC = (CIW_FILT_NS * CIW_CLK_MHZ + 999) / 1000;
endpackage : ciw_pkg

// ==== hdl/ciw_id_mem.sv ====
`timescale 1ns/1ps
`default_nettype none
// Identifier byte store, registered read data
module ciw_id_mem #(
	parameter int DEPTH = 16
) (
	input wire logic core_clk, // Clock
	input wire logic we, // Write strobe
	input wire logic [$clog2(DEPTH)-1:0] waddr, // Write address
	input wire logic [7:0] wdata, // Write data
	input wire logic [$clog2(DEPTH)-1:0] raddr, // Read address
	output logic [7:0] rdata // Registered read data
);
	logic [7:0] mem_q [DEPTH]; // Storage; identifiers have no reset value

	// Write port
	always_ff @(posedge core_clk) begin
		if (we) begin
			mem_q[waddr] <= wdata;
		end
	end

	// Read port, one cycle latency
	always_ff @(posedge core_clk) begin
		rdata <= mem_q[raddr];
	end
endmodule : ciw_id_mem
`default_nettype wire

// ==== hdl/ciw_top.sv ====
`timescale 1ns/1ps
`default_nettype none
module ciw_top
	import ciw_pkg::*;
(
	input wire logic core_clk, // 40 MHz clock
	input wire logic reset_n, // Async reset, active low
	input wire logic [7:0] avs_address, // Avalon word address
	input wire logic avs_read, // Avalon read
	input wire logic avs_write, // Avalon write
	input wire logic [31:0] avs_writedata, // Avalon write data
	input wire logic [3:0] avs_byteenable, // Avalon byte enables
	output logic [31:0] avs_readdata, // Avalon read data
	output logic avs_waitrequest, // Avalon wait request
	input wire logic receive_input_line, // CAN receive pin
	input wire logic status_change_evt, // Pulse: bus status changed
	input wire logic overrun_evt, // Pulse: receive overrun
	input wire logic receive_full_evt, // Pulse: frame received
	input wire logic [2:0] tx_done_evt, // Pulse per buffer: frame sent
	input wire logic rx_rtr_in, // Received RTR value
	input wire logic rx_load, // Pulse: store received RTR
	output logic [2:0] tx_sched, // Buffers scheduled
	output logic [1:0] tx_prio_buf, // Best scheduled buffer
	output logic tx_prio_valid, // Any buffer scheduled while clocks run
	output logic tx_rtr, // RTR of best buffer
	output logic can_clk_en, // Module clock gate
	output logic sleeping, // Sleep state
	output logic irq_wake, // Wake interrupt
	output logic irq_error, // Error interrupt
	output logic irq_rx, // Receive interrupt
	output logic irq_tx // Transmit interrupt
);
	// Register state, one flop group per concern
	logic [1:0] rx_sync_q; // Receive pin synchroniser
	logic [7:0] ctrl0_q; // control_reg_zero
	logic [7:0] ctrl1_q; // control_reg_one
	logic [7:0] rflg_q; // Receive flags
	logic [7:0] rier_q; // receive_irq_enable_reg
	logic [2:0] transmit_empty_flags_q; // Transmit-empty flags
	logic [2:0] transmit_empty_irq_enables_q; // transmit_irq_enable_reg
	logic [CIW_ID_W-1:0] ident_q [CIW_NUM_BUF]; // Shadow identifiers for ranking
	logic [CIW_NUM_BUF-1:0] rtr_q; // Shadow RTR bits
	logic [7:0] filt_cnt_q; // Glitch filter counter
	logic rx_prev_q; // Last synchronised receive level
	logic rd_pend_q; // Read answered next cycle
	logic mem_rd_q; // Pending read targets memory
	logic [7:0] rd_reg_q; // Registered register read data
	logic [7:0] mem_rdata; // Memory read data
	logic rtr_sel_q; // Pending read hits an RTR byte
	logic rtr_bit_q; // RTR bit captured for that read
	logic [7:0] id_rdata; // Identifier byte with live RTR bit
	logic acc_wr; // Write accepted
	logic [5:0] widx; // Word index
	logic is_id; // Address hits identifier bytes
	logic wake_evt; // Bus activity seen
	logic [7:0] rd_d; // Register read mux
	logic [1:0] best; // Ranking result
	logic found; // Ranking valid

	// Address decode; upper address bits must be zero for identifier hits and register reads, register writes ignore them
	assign widx = avs_address[5:0];
	assign is_id = (avs_address[7:6] == 2'h0) && (widx >= CIW_IDX_IDBASE)
		&& (widx < CIW_IDX_IDBASE + 6'(4 * CIW_NUM_BUF));
	// Only the low byte lane is decoded; writes with it off are dropped
	assign acc_wr = avs_write && avs_byteenable[0];
	// Reads take two cycles so memory data comes from its register
	assign avs_waitrequest = avs_read && !rd_pend_q;
	// Byte three of a buffer shows the live RTR bit, so a received frame's
	// remote flag is seen even though the receive path never writes memory
	assign id_rdata = {mem_rdata[7:1], rtr_sel_q ? rtr_bit_q : mem_rdata[0]};
	assign avs_readdata = {24'h0, mem_rd_q ? id_rdata : rd_reg_q};

	// Receive pin crossing: second stage is the only reader of the first
	// Reset to recessive so no false edge follows reset
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			rx_sync_q <= 2'h3;
		end else begin
			rx_sync_q <= {rx_sync_q[0], receive_input_line};
		end
	end

	// Wake detection on a dominant level; filter demands a sustained level
	// Counter saturates so one long dominant level gives a single wake
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			filt_cnt_q <= 8'h00;
			rx_prev_q <= 1'b1;
		end else if (rx_sync_q[1]) begin
			filt_cnt_q <= 8'h00;
			rx_prev_q <= 1'b1;
		end else begin
			rx_prev_q <= 1'b0;
			if (filt_cnt_q != 8'(CIW_FILT_CYC)) begin
				filt_cnt_q <= filt_cnt_q + 8'h01;
			end
		end
	end
	// Unfiltered: first dominant sample; filtered: pulse reached full length
	assign wake_evt = ctrl1_q[CIW_CTRL1_WFILT] ?
		(filt_cnt_q == 8'(CIW_FILT_CYC - 1) && !rx_sync_q[1]) :
		(rx_prev_q && !rx_sync_q[1]);

	// Control registers; wake clears the sleep request
	// A software write in the same cycle as a wake takes precedence
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			ctrl0_q <= CIW_CTRL0_RST;
			ctrl1_q <= CIW_CTRL1_RST;
		end else begin
			if (acc_wr && widx == CIW_IDX_CTRL1) begin
				ctrl1_q <= avs_writedata[7:0];
			end
			if (acc_wr && widx == CIW_IDX_CTRL0) begin
				ctrl0_q <= avs_writedata[7:0];
			end else if (sleeping && ctrl0_q[CIW_CTRL0_WAKE_EN] && wake_evt) begin
				ctrl0_q[CIW_CTRL0_SLEEP] <= 1'b0;
			end
		end
	end
	// Clocks run only when enabled and awake; register access never gated
	assign can_clk_en = ctrl1_q[CIW_CTRL1_MOD_EN] && !ctrl0_q[CIW_CTRL0_SLEEP];
	assign sleeping = ctrl0_q[CIW_CTRL0_SLEEP];

	// Receive flags: set wins over write-one-to-clear
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			rflg_q <= 8'h00;
		end else begin
			logic [7:0] set_v;
			logic [7:0] clr_v;
			set_v = 8'h00;
			clr_v = (acc_wr && widx == CIW_IDX_RFLG) ? avs_writedata[7:0] : 8'h00;
			set_v[CIW_RF_WAKE] = sleeping && ctrl0_q[CIW_CTRL0_WAKE_EN] && wake_evt;
			set_v[CIW_RF_CSC] = status_change_evt && can_clk_en;
			set_v[CIW_RF_OVR] = overrun_evt && can_clk_en;
			set_v[CIW_RF_RXF] = receive_full_evt && can_clk_en;
			rflg_q <= (rflg_q & ~clr_v) | set_v;
		end
	end

	// Enable registers
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			rier_q <= 8'h00;
			transmit_empty_irq_enables_q <= 3'h0;
		end else begin
			if (acc_wr && widx == CIW_IDX_RIER) begin
				rier_q <= avs_writedata[7:0];
			end
			if (acc_wr && widx == CIW_IDX_TIER) begin
				transmit_empty_irq_enables_q <= avs_writedata[2:0];
			end
		end
	end

	// Transmit-empty flags: scheduling clears, completion sets, completion wins
	// A buffer just sent is empty again even if scheduled in the same cycle
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			transmit_empty_flags_q <= CIW_TXE_RST;
		end else begin
			logic [2:0] sch_v;
			sch_v = (acc_wr && widx == CIW_IDX_TSCHED) ? avs_writedata[2:0] : 3'h0;
			transmit_empty_flags_q <= (transmit_empty_flags_q & ~sch_v) | tx_done_evt;
		end
	end
	assign tx_sched = ~transmit_empty_flags_q;

	// Shadow identifier and RTR per buffer, filled from byte writes
	// Receive buffer RTR follows the receive path between software writes
	generate
		for (genvar b = 0; b < CIW_NUM_BUF; b++) begin : g_buf
			always_ff @(posedge core_clk or negedge reset_n) begin
				if (!reset_n) begin
					ident_q[b] <= '0;
					rtr_q[b] <= 1'b0;
				end else if (acc_wr && is_id && (widx[3:2] == 2'(b))) begin
					case (widx[1:0])
						2'h0: ident_q[b][28:21] <= avs_writedata[7:0];
						2'h1: begin
							ident_q[b][20:18] <= avs_writedata[7:5];
							ident_q[b][17:15] <= avs_writedata[2:0];
						end
						2'h2: ident_q[b][14:7] <= avs_writedata[7:0];
						2'h3: begin
							ident_q[b][6:0] <= avs_writedata[7:1];
							rtr_q[b] <= avs_writedata[0];
						end
						default: ;
					endcase
				end else if (b == CIW_NUM_BUF - 1 && rx_load) begin
					rtr_q[b] <= rx_rtr_in;
				end
			end
		end
	endgenerate

	// Ranking: smallest identifier wins, lower buffer breaks ties
	// Only the three transmit buffers compete; the receive buffer never sends
	always_comb begin
		best = 2'h0;
		found = 1'b0;
		for (int i = 0; i < CIW_NUM_TX; i++) begin
			if (tx_sched[i] && (!found || ident_q[i] < ident_q[best])) begin
				best = 2'(i);
				found = 1'b1;
			end
		end
	end

	// Ranking result registered; bit 28 is the first arbitration bit out
	// Registered so the long compare chain stays off the outputs
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			tx_prio_buf <= 2'h0;
			tx_prio_valid <= 1'b0;
			tx_rtr <= 1'b0;
		end else begin
			tx_prio_buf <= best;
			tx_prio_valid <= found && can_clk_en;
			tx_rtr <= rtr_q[best];
		end
	end

	// Register read mux
	always_comb begin
		rd_d = 8'h00;
		case (widx)
			CIW_IDX_CTRL0: rd_d = ctrl0_q;
			CIW_IDX_CTRL1: rd_d = ctrl1_q;
			CIW_IDX_RFLG: rd_d = rflg_q;
			CIW_IDX_RIER: rd_d = rier_q;
			CIW_IDX_TFLG: rd_d = {5'h00, transmit_empty_flags_q};
			CIW_IDX_TIER: rd_d = {5'h00, transmit_empty_irq_enables_q};
			CIW_IDX_PRIO: rd_d = {tx_prio_valid, 5'h00, tx_prio_buf};
			default: rd_d = 8'h00;
		endcase
		if (avs_address[7:6] != 2'h0) begin
			rd_d = 8'h00;
		end
	end

	// Read pipeline: first cycle fetch, second cycle answer
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			rd_pend_q <= 1'b0;
			mem_rd_q <= 1'b0;
			rd_reg_q <= 8'h00;
			rtr_sel_q <= 1'b0;
			rtr_bit_q <= 1'b0;
		end else begin
			rd_pend_q <= avs_read && !rd_pend_q;
			if (avs_read && !rd_pend_q) begin
				mem_rd_q <= is_id;
				rd_reg_q <= rd_d;
				rtr_sel_q <= is_id && (widx[1:0] == 2'h3);
				rtr_bit_q <= rtr_q[widx[3:2]];
			end
		end
	end

	// Identifier bytes as software sees them
	ciw_id_mem #(
		.DEPTH(16)
	) ciw_id_mem_inst (
		.core_clk(core_clk),
		.we(acc_wr && is_id),
		.waddr(widx[3:0]),
		.wdata(avs_writedata[7:0]),
		.raddr(widx[3:0]),
		.rdata(mem_rdata)
	);

	// Interrupt levels, one per source group
	// One cycle behind the flags, trading latency for glitch-free levels
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			irq_wake <= 1'b0;
			irq_error <= 1'b0;
			irq_rx <= 1'b0;
			irq_tx <= 1'b0;
		end else begin
			irq_wake <= rflg_q[CIW_RF_WAKE] && rier_q[CIW_RF_WAKE];
			// Wake has its own output, so only status change and overrun count here
			irq_error <= (rflg_q[CIW_RF_CSC] && rier_q[CIW_RF_CSC])
				|| (rflg_q[CIW_RF_OVR] && rier_q[CIW_RF_OVR]);
			irq_rx <= rflg_q[CIW_RF_RXF] && rier_q[CIW_RF_RXF];
			irq_tx <= |(transmit_empty_flags_q & transmit_empty_irq_enables_q);
		end
	end
endmodule : ciw_top
`default_nettype wire

// ==== bench/ciw_bus_node.sv ====
`timescale 1ns/1ps
`default_nettype none
// Far-side CAN node seen through the transceiver
module ciw_bus_node (
	input wire logic core_clk, // Times the stretches
	output logic can_rx // Line level at the block
);
	initial can_rx = 1'b1; // Recessive while the bus is quiet
	// Dominant for n cycles, then back to recessive, which the transceiver idles at
	task automatic dominant(input int n);
		can_rx <= 1'b0;
		repeat (n) @(posedge core_clk);
		can_rx <= 1'b1;
	endtask : dominant
endmodule : ciw_bus_node
`default_nettype wire

// ==== bench/ciw_top_chk.sv ====
`timescale 1ns/1ps
`default_nettype none
// Port watcher; flags are internal, so irq edges are tied to their causes
module ciw_top_chk (
	input wire logic core_clk, // Clock
	input wire logic reset_n, // Reset, active low
	input wire logic avs_read, // Read strobe
	input wire logic avs_write, // Write strobe
	input wire logic [31:0] avs_readdata, // Read data
	input wire logic avs_waitrequest, // Wait request
	input wire logic status_change_evt, // Event
	input wire logic overrun_evt, // Event
	input wire logic receive_full_evt, // Event
	input wire logic [2:0] tx_done_evt, // Sent pulses
	input wire logic [2:0] tx_sched, // Scheduled
	input wire logic [1:0] tx_prio_buf, // Best buffer
	input wire logic tx_prio_valid, // Best valid
	input wire logic can_clk_en, // Clock gate
	input wire logic irq_error, // Irq
	input wire logic irq_rx, // Irq
	input wire logic irq_tx // Irq
);
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!reset_n);
	logic [3:0] sched_q; // Padded so index 3 reads as unscheduled
	// The best-buffer output is registered, so compare with last cycle
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) sched_q <= 4'h0;
		else sched_q <= {1'b0, tx_sched};
	end
	sequence s_rd_start; $rose(avs_read); endsequence
	property p_rd; s_rd_start |-> avs_waitrequest ##1 (!avs_waitrequest && avs_readdata[31:8] == 24'h0); endproperty
	a_rd: assert property (p_rd) else $error("read cycle wrong");
	property p_off; $rose(reset_n) |-> !can_clk_en; endproperty
	a_off: assert property (p_off) else $error("clocks run out of reset");
	property p_done; tx_done_evt != 3'h0 |=> (tx_sched & $past(tx_done_evt)) == 3'h0; endproperty
	a_done: assert property (p_done) else $error("sent buffer not empty");
	property p_prio; tx_prio_valid |-> sched_q[tx_prio_buf]; endproperty
	a_prio: assert property (p_prio) else $error("best buffer unscheduled");
	property p_rx_fall; $fell(irq_rx) |-> $past(avs_write, 2); endproperty
	a_rx_fall: assert property (p_rx_fall) else $error("rx irq dropped alone");
	property p_rx_rise; $rose(irq_rx) |-> $past(receive_full_evt, 2) || $past(avs_write, 2); endproperty
	a_rx_rise: assert property (p_rx_rise) else $error("rx irq without cause");
	property p_err_rise; $rose(irq_error) |-> $past(status_change_evt, 2) || $past(overrun_evt, 2) || $past(avs_write, 2); endproperty
	a_err_rise: assert property (p_err_rise) else $error("error irq without cause");
	property p_tx_rise; $rose(irq_tx) |-> $past(tx_done_evt, 2) != 3'h0 || $past(avs_write, 2); endproperty
	a_tx_rise: assert property (p_tx_rise) else $error("tx irq without cause");
endmodule : ciw_top_chk
bind ciw_top ciw_top_chk ciw_top_chk_inst (.core_clk(core_clk), .reset_n(reset_n),
	.avs_read(avs_read), .avs_write(avs_write), .avs_readdata(avs_readdata),
	.avs_waitrequest(avs_waitrequest), .status_change_evt(status_change_evt),
	.overrun_evt(overrun_evt), .receive_full_evt(receive_full_evt), .tx_done_evt(tx_done_evt),
	.tx_sched(tx_sched), .tx_prio_buf(tx_prio_buf), .tx_prio_valid(tx_prio_valid),
	.can_clk_en(can_clk_en), .irq_error(irq_error), .irq_rx(irq_rx), .irq_tx(irq_tx));
`default_nettype wire

// ==== bench/ciw_top_tb.sv ====
`timescale 1ns/1ps
`default_nettype none
// Register-level tests of identifiers, wake-up and interrupts
module ciw_top_tb;
	import ciw_pkg::*;
	logic core_clk = 1'b0; // Clock
	logic reset_n = 1'b0; // Reset, active low
	logic [7:0] adr = 8'h00; // Word address
	logic rd = 1'b0, wr = 1'b0; // Bus strobes
	logic [31:0] wdat = 32'h0, rdat, got; // Bus data
	logic wait_rq, rxl; // Wait request, bus line
	logic sc = 1'b0, ov = 1'b0, rf = 1'b0, rtr_in = 1'b0, ld = 1'b0; // Events
	logic [2:0] done = 3'h0, sched; // Sent pulses, schedule
	logic [1:0] pbuf; // Best buffer
	logic pval, prtr, cken, slp, iw, ie, ir, it; // Status outputs
	logic [7:0] fbit [3] = '{8'h40, 8'h02, 8'h01}; // Flag bit per event
	int err_total = 0, checks = 0, cyc = 0; // Counters
	initial forever #12.5 core_clk = ~core_clk;
	ciw_bus_node ciw_bus_node_inst (.core_clk(core_clk), .can_rx(rxl));
	ciw_top ciw_top_inst (.core_clk(core_clk), .reset_n(reset_n), .avs_address(adr),
		.avs_read(rd), .avs_write(wr), .avs_writedata(wdat), .avs_byteenable(4'hF),
		.avs_readdata(rdat), .avs_waitrequest(wait_rq), .receive_input_line(rxl),
		.status_change_evt(sc), .overrun_evt(ov), .receive_full_evt(rf), .tx_done_evt(done),
		.rx_rtr_in(rtr_in), .rx_load(ld), .tx_sched(sched), .tx_prio_buf(pbuf),
		.tx_prio_valid(pval), .tx_rtr(prtr), .can_clk_en(cken), .sleeping(slp),
		.irq_wake(iw), .irq_error(ie), .irq_rx(ir), .irq_tx(it));
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		checks++;
		if (g !== e) begin
			err_total++;
			$display("BAD %s exp %h got %h", n, e, g);
		end
	endtask : chk
	// One Avalon access; waits on waitrequest, the timeout bounds it
	task automatic bus(input logic w, input logic [5:0] idx, input logic [7:0] d);
		adr <= {2'b00, idx};
		wdat <= {24'h0, d};
		wr <= w;
		rd <= !w;
		@(posedge core_clk);
		while (wait_rq !== 1'b0) @(posedge core_clk);
		got = rdat;
		wr <= 1'b0;
		rd <= 1'b0;
		@(posedge core_clk);
	endtask : bus
	task automatic rchk(input string n, input logic [5:0] idx, input logic [31:0] e);
		bus(1'b0, idx, 8'h00);
		chk(n, e, got);
	endtask : rchk
	task automatic tick(input int n);
		repeat (n) @(posedge core_clk);
	endtask : tick
	task automatic setid(input int b, input logic [28:0] id, input logic r);
		logic [7:0] v [4];
		v = '{id[28:21], {id[20:18], 2'b00, id[17:15]}, id[14:7], {id[6:0], r}};
		for (int k = 0; k < 4; k++) bus(1'b1, CIW_IDX_IDBASE + 6'(4 * b + k), v[k]);
		for (int k = 0; k < 4; k++) rchk("id", CIW_IDX_IDBASE + 6'(4 * b + k), {24'h0, v[k]});
	endtask : setid
	task automatic finish_test;
		$display("checks %0d mismatches %0d", checks, err_total);
		if (err_total == 0 && checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : finish_test
	// Hang guard, far above the run's length
	always @(posedge core_clk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			err_total++;
			finish_test();
		end
	end
	initial begin
		tick(16);
		reset_n <= 1'b1;
		tick(1);
		chk("cken", 0, cken);
		rchk("ctrl1", CIW_IDX_CTRL1, 32'h0);
		rchk("tflg", CIW_IDX_TFLG, 32'h7);
		rchk("unmapped", 6'h08, 32'h0);
		chk("irqs", 0, {iw, ie, ir, it});
		$display("test reset done");
		// Smallest id wins; buffer 1 carries RTR, byte zero decides 2 over 0
		bus(1'b1, CIW_IDX_CTRL1, 8'h80);
		chk("cken", 1, cken);
		setid(0, 29'h1000_0000, 1'b0);
		setid(1, 29'h0000_0001, 1'b1);
		setid(2, 29'h0000_0080, 1'b0);
		setid(3, 29'h0000_0000, 1'b0);
		bus(1'b1, CIW_IDX_TSCHED, 8'h07);
		tick(2);
		chk("sched", 3'h7, sched);
		rchk("prio", CIW_IDX_PRIO, 32'h81);
		chk("rtr", 1, prtr);
		done <= 3'h2;
		tick(1);
		done <= 3'h0;
		tick(2);
		rchk("tflg", CIW_IDX_TFLG, 32'h2);
		rchk("prio", CIW_IDX_PRIO, 32'h82);
		chk("rtr", 0, prtr);
		bus(1'b1, CIW_IDX_TIER, 8'h02);
		tick(2);
		chk("irq_tx", 1, it);
		bus(1'b1, CIW_IDX_TIER, 8'h05);
		tick(2);
		chk("irq_tx", 0, it);
		$display("test transmit done");
		// Every event masked, then enabled; flags stay sticky until cleared
		for (int m = 0; m < 2; m++) begin
			bus(1'b1, CIW_IDX_RIER, m ? 8'h43 : 8'h00);
			for (int e = 0; e < 3; e++) begin
				{sc, ov, rf} <= 3'b100 >> e;
				tick(1);
				{sc, ov, rf} <= 3'b000;
				tick(3);
				chk("irq_err", m && e < 2, ie);
				chk("irq_rx", m && e == 2, ir);
				rchk("rflg", CIW_IDX_RFLG, {24'h0, fbit[e]});
				bus(1'b1, CIW_IDX_RFLG, 8'hFF);
				tick(3);
				chk("irq_clr", 0, {ie, ir});
			end
		end
		$display("test receive done");
		// Bus activity while asleep wakes; with the filter a glitch does not
		bus(1'b1, CIW_IDX_RIER, 8'h80);
		bus(1'b1, CIW_IDX_CTRL0, 8'h05);
		tick(2);
		chk("sleep", 1, slp);
		chk("cken_slp", 0, cken);
		ciw_bus_node_inst.dominant(10);
		tick(4);
		chk("irq_wake", 1, iw);
		chk("awake", 0, slp);
		bus(1'b1, CIW_IDX_RFLG, 8'h80);
		bus(1'b1, CIW_IDX_CTRL1, 8'h84);
		bus(1'b1, CIW_IDX_CTRL0, 8'h05);
		ciw_bus_node_inst.dominant(CIW_FILT_CYC / 4);
		tick(4);
		chk("glitch", 0, iw);
		ciw_bus_node_inst.dominant(CIW_FILT_CYC + 20);
		tick(4);
		chk("irq_wake", 1, iw);
		chk("awake_filt", 0, slp);
		$display("test wake done");
		// Received RTR lands in the receive buffer's byte three
		rtr_in <= 1'b1;
		ld <= 1'b1;
		tick(1);
		ld <= 1'b0;
		tick(2);
		rchk("rx_rtr", CIW_IDX_IDBASE + 6'd15, 32'h01);
		$display("test rtr done");
		finish_test();
	end
endmodule : ciw_top_tb
`default_nettype wire
